/* rtl/sep_target.sv */
// target end: two-wire protocol engine of the serial byte memory
//
// Behaviour
// (RQ1) eight-bit address word follows every start
// (RQ2) three address bits must match strap pins
// (RQ3) address lsb selects read or write
// (RQ4) match acks low; mismatch returns to idle
// (RQ5) nibble 1011 selects the serial block
// (RQ6) serial block is never written
// (RQ7) byte write: acks, then stop programs
// (RQ8) no response while programming runs
// (RQ9) page write takes up to eight bytes
// (RQ10) writes wrap within page, low three bits
// (RQ11) address polling acked only after programming
// (RQ12) pointer holds last address plus one
// (RQ13) reads wrap across the whole array
// (RQ14) current read sends byte at pointer
// (RQ15) random read: dummy write, restart, read
// (RQ16) sequential read continues while controller acks
// (RQ17) one pointer shared by array and serial
// (RQ18) serial word address needs 10 prefix
// (RQ19) serial reads wrap after sixteenth byte
// (RQ20) controller should read all sixteen serial bytes
// (RQ21) eight-bit words, ack on ninth clock
// (RQ22) programming ends within programming_cycle_time; here busy counts all of it and overruns it by the toggle hand-over
// (RQ23) array depth 128 or 256 bytes
`timescale 1ns/1ps
`include "sep_defs.svh"
module sep_target #(
  parameter int DEPTH = `SEP_ARRAY_DEPTH,
  parameter int PROG_CYCLES = `SEP_PROG_CYCLES,
  // arbitrary serial number value
  parameter logic [127:0] SERIAL_NUMBER = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
  // system side
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  output logic PROG_BUSY_O,
  output logic PROG_DONE_O,
  // link side
  input wire logic LINK_CLK_I,
  input wire logic [2:0] STRAP_I,
  output sep_pkg::sep_tgt_state_e STATE_O,
  sep_link_if.target LINK
);
  import sep_pkg::*;

  localparam logic [7:0] ADDR_MASK = 8'(DEPTH - 1); // see (RQ23)
  localparam int CW = $clog2(PROG_CYCLES + 1);

  // ----------------------------------------------------------------
  // link domain reset and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_l_r;
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic [2:0] strap_m_r, strap_s_r;

  // reset is carried into the link clock through two flops
  always_ff @(posedge LINK_CLK_I)
  begin
    rst_l_r <= {rst_l_r[0], SYS_RST_I};
  end

  // pins pass two flops; a third flop gives the edge reference
  always_ff @(posedge LINK_CLK_I)
  begin
    scl_m_r <= LINK.scl;
    scl_s_r <= scl_m_r;
    scl_d_r <= scl_s_r;
    sda_m_r <= LINK.sda;
    sda_s_r <= sda_m_r;
    sda_d_r <= sda_s_r;
    strap_m_r <= STRAP_I;
    strap_s_r <= strap_m_r;
  end

  wire rst_l = rst_l_r[1];
  wire start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  wire stop_ev = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  wire rise_ev = scl_s_r & ~scl_d_r;
  wire fall_ev = ~scl_s_r & scl_d_r;

  // ----------------------------------------------------------------
  // protocol state
  // ----------------------------------------------------------------
  sep_tgt_state_e state_r;
  logic [3:0] bit_r;
  logic [7:0] shift_r;
  logic sda_oe_n_r;
  logic sel_serial_r;
  logic mack_r;
  logic busy_r;
  logic [7:0] ptr_r;
  logic [7:0] mem_r [DEPTH];
  logic [7:0] pg_data_r [`SEP_PAGE_BYTES];
  logic [7:0] pg_valid_r;
  logic [7:0] rd_byte;
  logic [7:0] ptr_rd_nxt;

  wire byte_end = fall_ev & (bit_r == 4'h8);
  wire slot_end = fall_ev & (bit_r == 4'h9);
  wire nib_ok = (shift_r[7:4] == `SEP_ARRAY_NIBBLE) | (shift_r[7:4] == `SEP_SERIAL_NIBBLE);
  wire dev_hit = nib_ok & (shift_r[3:1] == strap_s_r); // see (RQ2)
  wire wr_data = byte_end & (state_r == ST_WDATA) & ~sel_serial_r;
  wire commit = stop_ev & ~busy_r & (pg_valid_r != 8'h00); // see (RQ7)

  // byte to send: serial block needs the 10 prefix, else undefined
  always_comb
  begin
    if (sel_serial_r)
    begin
      if (ptr_r[7:6] == `SEP_SERIAL_PREFIX) // see (RQ18)
        rd_byte = SERIAL_NUMBER[(4'hF - ptr_r[3:0]) * 8 +: 8];
      else
        rd_byte = `SEP_UNDEF_DATA;
    end
    else
    begin
      rd_byte = mem_r[ptr_r & ADDR_MASK];
    end
  end

  // serial reads wrap in 16 bytes, array reads across the array
  always_comb
  begin
    if (sel_serial_r)
      ptr_rd_nxt = {ptr_r[7:4], ptr_r[3:0] + 4'h1}; // see (RQ19)
    else
      ptr_rd_nxt = (ptr_r + 8'h01) & ADDR_MASK; // see (RQ13)
  end

  // bit and byte sequencing; open-drain, so a one simply releases
  always_ff @(posedge LINK_CLK_I)
  begin
    if (rst_l)
    begin
      state_r <= ST_IDLE;
      bit_r <= 4'h0;
      shift_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
      sel_serial_r <= 1'b0;
      mack_r <= 1'b0;
    end
    else if (busy_r)
    begin
      state_r <= ST_IDLE; // see (RQ8) (RQ11)
      sda_oe_n_r <= 1'b1;
    end
    else if (start_ev)
    begin
      state_r <= ST_DEVADDR; // see (RQ1)
      bit_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end
    else if (stop_ev)
    begin
      state_r <= ST_IDLE;
      sda_oe_n_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        ST_DEVADDR, ST_WADDR, ST_WDATA, ST_RSTART:
        begin
          if (rise_ev && bit_r < 4'h8)
          begin
            shift_r <= {shift_r[6:0], sda_s_r}; // see (RQ21)
            bit_r <= bit_r + 4'h1;
          end
          else if (byte_end)
          begin
            bit_r <= 4'h9;
            if (state_r == ST_DEVADDR)
            begin
              if (dev_hit)
              begin
                sda_oe_n_r <= 1'b0; // see (RQ4)
                sel_serial_r <= shift_r[4]; // see (RQ5) (RQ17)
                state_r <= shift_r[0] ? ST_RSTART : ST_WADDR; // see (RQ3)
              end
              else
              begin
                state_r <= ST_IDLE; // see (RQ4)
              end
            end
            else if (state_r == ST_WDATA && sel_serial_r)
              state_r <= ST_IDLE; // see (RQ6)
            else
            begin
              sda_oe_n_r <= 1'b0; // see (RQ7) (RQ9)
              state_r <= ST_WDATA;
            end
          end
          else if (slot_end)
          begin
            bit_r <= 4'h0;
            sda_oe_n_r <= 1'b1;
            if (state_r == ST_RSTART)
            begin
              state_r <= ST_RDATA; // see (RQ14)
              sda_oe_n_r <= rd_byte[7];
              shift_r <= {rd_byte[6:0], 1'b1};
            end
          end
        end
        ST_RDATA:
        begin
          if (rise_ev && bit_r < 4'h8)
            bit_r <= bit_r + 4'h1;
          else if (fall_ev && bit_r != 4'h0 && bit_r < 4'h8)
          begin
            sda_oe_n_r <= shift_r[7];
            shift_r <= {shift_r[6:0], 1'b1};
          end
          else if (byte_end)
          begin
            bit_r <= 4'h9;
            sda_oe_n_r <= 1'b1; // controller owns the ninth bit
          end
          else if (rise_ev && bit_r == 4'h9)
            mack_r <= ~sda_s_r;
          else if (slot_end)
          begin
            bit_r <= 4'h0;
            if (mack_r)
            begin
              sda_oe_n_r <= rd_byte[7]; // see (RQ16)
              shift_r <= {rd_byte[6:0], 1'b1};
            end
            else
              state_r <= ST_IDLE;
          end
        end
        default:
        begin
          sda_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  // shared address pointer, kept across transfers
  always_ff @(posedge LINK_CLK_I)
  begin
    if (rst_l)
      ptr_r <= 8'h00;
    else if (byte_end && state_r == ST_WADDR)
      ptr_r <= sel_serial_r ? shift_r : (shift_r & ADDR_MASK); // see (RQ17) (RQ23)
    else if (wr_data)
      ptr_r <= {ptr_r[7:3], ptr_r[2:0] + 3'h1}; // see (RQ10)
    else if (byte_end && state_r == ST_RDATA)
      ptr_r <= ptr_rd_nxt; // see (RQ12)
  end

  // page buffer: later bytes at the same slot overwrite earlier ones
  always_ff @(posedge LINK_CLK_I)
  begin
    if (rst_l || start_ev || commit)
      pg_valid_r <= 8'h00;
    else if (wr_data)
    begin
      pg_data_r[ptr_r[2:0]] <= shift_r; // see (RQ10)
      pg_valid_r[ptr_r[2:0]] <= 1'b1;
    end
  end

  // array update at stop; the array itself is not reset
  always_ff @(posedge LINK_CLK_I)
  begin
    if (commit)
    begin
      for (int i = 0; i < `SEP_PAGE_BYTES; i++)
      begin
        if (pg_valid_r[i])
          mem_r[{ptr_r[7:3], 3'(i)}] <= pg_data_r[i]; // see (RQ9)
      end
    end
  end

  // ----------------------------------------------------------------
  // programming timer, handed to the system clock by toggles
  // ----------------------------------------------------------------
  logic req_tgl_r;
  logic [2:0] done_sync_r;
  logic [2:0] req_sync_r;
  logic done_tgl_r;
  logic [CW-1:0] cnt_r;
  logic run_r;

  // busy spans from the stop until the timer answers back
  always_ff @(posedge LINK_CLK_I)
  begin
    if (rst_l)
    begin
      busy_r <= 1'b0;
      req_tgl_r <= 1'b0;
      done_sync_r <= 3'h0;
    end
    else
    begin
      done_sync_r <= {done_sync_r[1:0], done_tgl_r};
      if (commit)
      begin
        busy_r <= 1'b1; // see (RQ8)
        req_tgl_r <= ~req_tgl_r;
      end
      else if (done_sync_r[2] != done_sync_r[1])
        busy_r <= 1'b0; // see (RQ11)
    end
  end

  // counts all of PROG_CYCLES, so the busy span runs past the maximum by the toggle hand-over
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      req_sync_r <= 3'h0;
      done_tgl_r <= 1'b0;
      cnt_r <= '0;
      run_r <= 1'b0;
      PROG_DONE_O <= 1'b0;
    end
    else
    begin
      req_sync_r <= {req_sync_r[1:0], req_tgl_r};
      PROG_DONE_O <= 1'b0;
      if (req_sync_r[2] != req_sync_r[1])
      begin
        run_r <= 1'b1;
        cnt_r <= CW'(PROG_CYCLES - 1); // see (RQ22)
      end
      else if (run_r && cnt_r == '0)
      begin
        run_r <= 1'b0;
        done_tgl_r <= ~done_tgl_r;
        PROG_DONE_O <= 1'b1;
      end
      else if (run_r)
        cnt_r <= cnt_r - 1'b1;
    end
  end

  assign PROG_BUSY_O = run_r;
  assign STATE_O = state_r;
  assign LINK.tgt_sda_o = 1'b0;
  assign LINK.tgt_sda_oe_n = sda_oe_n_r;
endmodule

/* common/sep_defs.svh */
// constants shared by both ends of the serial memory link
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH

// device address word: upper nibble selects the area
`define SEP_ARRAY_NIBBLE 4'hA
`define SEP_SERIAL_NIBBLE 4'hB

// serial block word address prefix and size
`define SEP_SERIAL_PREFIX 2'h2
`define SEP_SERIAL_BYTES 16
`define SEP_UNDEF_DATA 8'hFF

// page geometry
`define SEP_PAGE_BYTES 8
`define SEP_ARRAY_DEPTH 256

// programming_cycle_time in ms, system clock in Hz, derived cycle count
`define SEP_PROG_TIME_MS 5
`define SEP_CLK_SYS_HZ 25000000
`define SEP_PROG_CYCLES (`SEP_PROG_TIME_MS * (`SEP_CLK_SYS_HZ / 1000))

// controller clock divider: system cycles per quarter of a link clock
`define SEP_SCL_QUARTER 16

`endif

/* common/sep_pkg.sv */
// types shared by both ends of the serial memory link
package sep_pkg;

  // byte-level operations accepted by the controller end
  typedef enum logic [1:0] {SEP_OP_START, SEP_OP_STOP, SEP_OP_WRITE, SEP_OP_READ} sep_op_e;

  // target protocol states
  typedef enum logic [2:0] {
    ST_IDLE, ST_DEVADDR, ST_WADDR, ST_WDATA, ST_RSTART, ST_RDATA
  } sep_tgt_state_e;

  // controller states
  typedef enum logic {CS_IDLE, CS_RUN} sep_ctl_state_e;

endpackage

/* common/sep_link_if.sv */
// two-wire link between controller and target, with wired-and data line
`timescale 1ns/1ps
interface sep_link_if;
  logic scl;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic tgt_sda_o;
  logic tgt_sda_oe_n;
  logic sda;

  // pulled-up line: low when any enabled driver pulls low
  assign sda = ~((~ctl_sda_oe_n & ~ctl_sda_o) | (~tgt_sda_oe_n & ~tgt_sda_o));

  modport controller (output scl, output ctl_sda_o, output ctl_sda_oe_n, input sda);
  modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe_n);
endinterface

/* rtl/sep_controller.sv */
// controller end: byte-level two-wire bus master with its own clock divider
`timescale 1ns/1ps
`include "sep_defs.svh"
module sep_controller #(
  parameter int QUARTER = `SEP_SCL_QUARTER
) (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // command port
  input wire logic CMD_VALID_I,
  output logic CMD_READY_O,
  input sep_pkg::sep_op_e CMD_OP_I,
  input wire logic [7:0] CMD_DATA_I,
  input wire logic CMD_ACK_I,
  // response port
  output logic RSP_VALID_O,
  output logic [7:0] RSP_DATA_O,
  output logic RSP_ACK_O,
  // link side
  sep_link_if.controller LINK
);
  import sep_pkg::*;

  localparam int TW = $clog2(QUARTER + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sep_ctl_state_e state_r;
  sep_op_e op_r;
  logic [TW-1:0] tq_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [8:0] tx_r;
  logic [8:0] rx_r;
  logic scl_r;
  logic sda_oe_n_r;
  logic sda_m_r, sda_s_r;

  wire tick = (state_r == CS_RUN) && (tq_r == TW'(QUARTER - 1));
  wire accept = CMD_VALID_I && (state_r == CS_IDLE);

  // the data line comes from outside this clock, two flops first
  always_ff @(posedge CLK_SYS_I)
  begin
    sda_m_r <= LINK.sda;
    sda_s_r <= sda_m_r;
  end

  // quarter-period divider, restarted for every command
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I || accept || tick)
      tq_r <= '0;
    else if (state_r == CS_RUN)
      tq_r <= tq_r + 1'b1;
  end

  // one quarter per phase; the clock rests low after a start or a byte
  // and high after a stop, so the data line moves with the clock high only for a start or a stop
  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      state_r <= CS_IDLE;
      op_r <= SEP_OP_STOP;
      ph_r <= 2'h0;
      bit_r <= 4'h0;
      tx_r <= 9'h1FF;
      rx_r <= 9'h000;
      scl_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
      RSP_VALID_O <= 1'b0;
      RSP_DATA_O <= 8'h00;
      RSP_ACK_O <= 1'b0;
    end
    else
    begin
      RSP_VALID_O <= 1'b0;
      if (accept)
      begin
        state_r <= CS_RUN;
        op_r <= CMD_OP_I;
        ph_r <= 2'h0;
        bit_r <= 4'h0;
        // write sends data then releases; read releases then acks or not
        tx_r <= (CMD_OP_I == SEP_OP_WRITE) ? {CMD_DATA_I, 1'b1} : {8'hFF, ~CMD_ACK_I}; // see (RQ14) (RQ16)
      end
      else if (tick)
      begin
        ph_r <= ph_r + 2'h1;
        case (op_r)
          SEP_OP_START:
          begin
            case (ph_r)
              2'h0: sda_oe_n_r <= 1'b1;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b0; // see (RQ1) (RQ15)
              default:
              begin
                scl_r <= 1'b0;
                state_r <= CS_IDLE;
              end
            endcase
          end
          SEP_OP_STOP:
          begin
            case (ph_r)
              2'h0: sda_oe_n_r <= 1'b0;
              2'h1: scl_r <= 1'b1;
              2'h2: sda_oe_n_r <= 1'b1; // see (RQ7) (RQ9) (RQ11)
              default: state_r <= CS_IDLE;
            endcase
          end
          default:
          begin
            case (ph_r)
              2'h0: sda_oe_n_r <= tx_r[8];
              2'h1: scl_r <= 1'b1;
              2'h2: rx_r <= {rx_r[7:0], sda_s_r};
              default:
              begin
                scl_r <= 1'b0;
                tx_r <= {tx_r[7:0], 1'b1};
                bit_r <= bit_r + 4'h1;
                // let go with the fall after the last data bit, so the target's
                // acknowledge never meets a low still held from this end
                if (bit_r == 4'h7)
                  sda_oe_n_r <= 1'b1;
                if (bit_r == 4'h8) // see (RQ21)
                begin
                  state_r <= CS_IDLE;
                  sda_oe_n_r <= 1'b1;
                  RSP_VALID_O <= 1'b1;
                  RSP_DATA_O <= rx_r[8:1];
                  RSP_ACK_O <= ~rx_r[0];
                end
              end
            endcase
          end
        endcase
      end
    end
  end

  assign CMD_READY_O = (state_r == CS_IDLE);
  assign LINK.scl = scl_r;
  assign LINK.ctl_sda_o = 1'b0;
  assign LINK.ctl_sda_oe_n = sda_oe_n_r;
endmodule

/* verification/sep_link_monitor.sv */
// protocol checker watching the two-wire link between the two ends
`timescale 1ns/1ps
module sep_link_monitor (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic SYS_RST_I,
  // link lines
  input wire logic scl,
  input wire logic ctl_sda_o,
  input wire logic ctl_sda_oe_n,
  input wire logic tgt_sda_o,
  input wire logic tgt_sda_oe_n,
  input wire logic sda
);
  // link lines are sampled on the system clock, many times per scl level
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_scl_hold;
    scl [*8];
  endsequence
  sequence s_tgt_quiet;
    $stable(tgt_sda_oe_n) [*2];
  endsequence
  sequence s_tgt_released;
    tgt_sda_oe_n [*8];
  endsequence
  property p_idle_after_reset;
    $fell(SYS_RST_I) |-> scl && ctl_sda_oe_n && tgt_sda_oe_n;
  endproperty
  // a stop puts the target in standby, so it must leave the line alone
  property p_quiet_after_stop;
    scl && $past(scl) && $rose(sda) |=> s_tgt_released;
  endproperty
  property p_no_fight;
    !ctl_sda_oe_n |-> tgt_sda_oe_n;
  endproperty
  property p_tgt_scl_low;
    $changed(tgt_sda_oe_n) |-> !scl && !$past(scl);
  endproperty
  property p_start_by_ctl;
    scl && $past(scl) && $fell(sda) |-> !ctl_sda_oe_n;
  endproperty
  property p_stop_by_ctl;
    scl && $past(scl) && $rose(sda) |-> $rose(ctl_sda_oe_n);
  endproperty
  property p_scl_high;
    $rose(scl) |=> s_scl_hold;
  endproperty
  property p_tgt_after_fall;
    $fell(scl) |-> s_tgt_quiet;
  endproperty

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("link not idle after reset");
  a_quiet_after_stop: assert property (p_quiet_after_stop)
    else $error("target drives the data line after a stop");
  a_no_fight: assert property (p_no_fight)
    else $error("both ends pull the data line");
  a_tgt_scl_low: assert property (p_tgt_scl_low)
    else $error("target changed data while clock high");
  a_start_by_ctl: assert property (p_start_by_ctl)
    else $error("start not made by controller");
  a_stop_by_ctl: assert property (p_stop_by_ctl)
    else $error("stop not made by controller");
  a_scl_high: assert property (p_scl_high)
    else $error("clock high phase too short");
  a_tgt_after_fall: assert property (p_tgt_after_fall)
    else $error("target changed data too soon after clock fall");
endmodule

/* verification/serial_eeprom_target_protocol_test.sv */
// self-checking bench joining the controller and target ends of the link
`timescale 1ns/1ps
module serial_eeprom_target_protocol_test;
  import sep_pkg::*;
  // shortened programming time still spans several polling rounds
  localparam int PROG = 2000;
  localparam logic [127:0] SN = 128'hC3A51E0F778899112468ACE013579BDF;
  localparam logic [2:0] STRAP = 3'h5;
  logic clk_sys = 1'b0;
  logic link_clk = 1'b0;
  logic rst;
  logic [2:0] strap = STRAP;
  logic cmd_valid, cmd_ready, cmd_ack, rsp_valid, rsp_ack, busy, done;
  logic [7:0] cmd_data, rsp_data;
  sep_op_e cmd_op;
  sep_tgt_state_e state;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;

  sep_link_if link_if ();
  sep_controller #(.QUARTER(16)) sep_controller_inst (.CLK_SYS_I(clk_sys), .SYS_RST_I(rst),
    .CMD_VALID_I(cmd_valid), .CMD_READY_O(cmd_ready), .CMD_OP_I(cmd_op),
    .CMD_DATA_I(cmd_data), .CMD_ACK_I(cmd_ack), .RSP_VALID_O(rsp_valid),
    .RSP_DATA_O(rsp_data), .RSP_ACK_O(rsp_ack), .LINK(link_if.controller));
  sep_target #(.DEPTH(256), .PROG_CYCLES(PROG), .SERIAL_NUMBER(SN)) sep_target_inst (
    .CLK_SYS_I(clk_sys), .SYS_RST_I(rst), .PROG_BUSY_O(busy), .PROG_DONE_O(done),
    .LINK_CLK_I(link_clk), .STRAP_I(strap), .STATE_O(state), .LINK(link_if.target));
  sep_link_monitor sep_link_monitor_inst (.CLK_SYS_I(clk_sys), .SYS_RST_I(rst),
    .scl(link_if.scl), .ctl_sda_o(link_if.ctl_sda_o), .ctl_sda_oe_n(link_if.ctl_sda_oe_n),
    .tgt_sda_o(link_if.tgt_sda_o), .tgt_sda_oe_n(link_if.tgt_sda_oe_n), .sda(link_if.sda));

  // clocks: link clock offset so the two never line up
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  initial
  begin
    #7;
    forever #32 link_clk = ~link_clk;
  end

  task automatic complete_run();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ceiling well above the roughly 60k cycles the scenarios need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 99000)
    begin
      errors++;
      complete_run();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // entered and left at 1 ns after an edge with ready high
  task automatic cmd(input sep_op_e op, input logic [7:0] d, input logic a);
    cmd_op = op;
    cmd_data = d;
    cmd_ack = a;
    cmd_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    cmd_valid = 1'b0;
    do
    begin
      @(posedge clk_sys);
      #1;
    end
    while (cmd_ready !== 1'b1);
    chk("rsp_valid", {7'h0, op == SEP_OP_WRITE || op == SEP_OP_READ},
      {7'h0, rsp_valid});
  endtask

  function automatic logic [7:0] dev(input logic [3:0] n, input logic rw);
    return {n, STRAP, rw};
  endfunction
  // page loaded from 1E with 40..48: the ninth byte overwrote 1E
  function automatic logic [7:0] pg(input logic [7:0] a);
    logic [2:0] i;
    i = a[2:0] - 3'h6;
    return (i == 3'h0) ? 8'h48 : 8'h40 + {5'h0, i};
  endfunction

  task automatic st();
    cmd(SEP_OP_START, 8'h00, 1'b0);
  endtask
  task automatic sp();
    cmd(SEP_OP_STOP, 8'h00, 1'b0);
  endtask
  task automatic wr(input logic [7:0] d, input logic a);
    cmd(SEP_OP_WRITE, d, 1'b0);
    chk("ack", {7'h0, a}, {7'h0, rsp_ack});
  endtask
  task automatic rd(input logic a, input logic [7:0] e);
    cmd(SEP_OP_READ, 8'h00, a);
    chk("read", e, rsp_data);
  endtask
  // dummy write of a word address, then restart in read direction
  task automatic seek(input logic [3:0] n, input logic [7:0] a);
    st();
    wr(dev(n, 1'b0), 1'b1);
    wr(a, 1'b1);
    st();
    wr(dev(n, 1'b1), 1'b1);
  endtask
  // polls until acked and leaves the bus open for a word address
  task automatic poll();
    int n;
    n = 0;
    st();
    cmd(SEP_OP_WRITE, dev(4'hA, 1'b0), 1'b0);
    while (rsp_ack !== 1'b1 && n < 20)
    begin
      sp();
      st();
      cmd(SEP_OP_WRITE, dev(4'hA, 1'b0), 1'b0);
      n++;
    end
    chk("poll", 8'h01, {7'h0, rsp_ack});
  endtask

  task automatic t_address();
    st();
    wr({4'hA, ~STRAP, 1'b0}, 1'b0);
    wr(dev(4'hA, 1'b0), 1'b0);
    sp();
    chk("state", 8'(ST_IDLE), 8'(state));
    st();
    wr(dev(4'h9, 1'b1), 1'b0);
    sp();
    // the compare follows the pins, not a fixed value
    strap = ~STRAP;
    st();
    wr({4'hA, ~STRAP, 1'b0}, 1'b1);
    sp();
    strap = STRAP;
  endtask

  task automatic t_page();
    time t0;
    st();
    wr(dev(4'hA, 1'b0), 1'b1);
    wr(8'h1E, 1'b1);
    for (int i = 0; i < 9; i++)
      wr(8'h40 + i[7:0], 1'b1);
    sp();
    t0 = $time;
    chk("busy", 8'h01, {7'h0, busy});
    st();
    wr(dev(4'hA, 1'b1), 1'b0);
    sp();
    do
    begin
      @(posedge clk_sys);
      #1;
    end
    while (done !== 1'b1);
    chk("prog_time", 8'h01, 8'((($time - t0) / 40) inside {[PROG - 20 : PROG + 40]}));
    poll();
    wr(8'h18, 1'b1);
    st();
    wr(dev(4'hA, 1'b1), 1'b1);
    for (int i = 0; i < 8; i++)
      rd(i < 7, pg(8'h18 + i[7:0]));
    sp();
    seek(4'hA, 8'h1D);
    rd(1'b0, 8'h47);
    sp();
    for (int i = 0; i < 2; i++)
    begin
      st();
      wr(dev(4'hA, 1'b1), 1'b1);
      rd(1'b0, pg(8'h1E + i[7:0]));
      sp();
    end
  endtask

  task automatic t_wrap();
    poll();
    wr(8'hFF, 1'b1);
    wr(8'h5A, 1'b1);
    sp();
    poll();
    wr(8'h00, 1'b1);
    wr(8'hA5, 1'b1);
    sp();
    poll();
    wr(8'hFF, 1'b1);
    st();
    wr(dev(4'hA, 1'b1), 1'b1);
    rd(1'b1, 8'h5A);
    rd(1'b0, 8'hA5);
    sp();
  endtask

  task automatic t_serial();
    st();
    wr(dev(4'hB, 1'b0), 1'b1);
    wr(8'h80, 1'b1);
    wr(8'h00, 1'b0);
    sp();
    seek(4'hB, 8'h80);
    for (int i = 0; i < 17; i++)
      rd(i < 16, SN[127 - 8 * (i % 16) -: 8]);
    sp();
    seek(4'hB, 8'h00);
    rd(1'b0, 8'hFF);
    sp();
    // array byte 7F is written first so the read never puts unknowns on the line
    poll();
    wr(8'h7F, 1'b1);
    wr(8'hC6, 1'b1);
    sp();
    poll();
    wr(8'h7F, 1'b1);
    st();
    wr(dev(4'hA, 1'b1), 1'b1);
    rd(1'b0, 8'hC6);
    sp();
    st();
    wr(dev(4'hB, 1'b1), 1'b1);
    rd(1'b0, SN[127:120]);
    sp();
  endtask

  initial
  begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = SEP_OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    // seven cycles so the link domain also sees four reset edges
    repeat (7) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    t_address();
    t_page();
    t_wrap();
    t_serial();
    complete_run();
  end
endmodule
